// ### hdl/lpm_pkg.sv
// constants and types for the low-power mode and wake-up controller
// assumes a classic wishbone master with byte-wide registers on lane 0
package lpm_pkg;

	// bus geometry
	localparam int          DATA_W       = 32;
	localparam int          REG_W        = 8;
	localparam int          ADR_W        = 12;
	localparam int          IDX_LSB      = 2;
	localparam int          IDX_W        = 8;

	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_OSC_MODE  = 8'h95;
	localparam logic [7:0]  IDX_IRQ_REQ   = 8'h98;
	localparam logic [7:0]  IDX_IRQ_EN    = 8'h9B;
	localparam logic [7:0]  IDX_P1_WAKE   = 8'h9E;
	localparam logic [7:0]  IDX_WAKE_STAT = 8'hA0;
	localparam logic [7:0]  IDX_EXT_EN    = 8'hA1;

	// oscillator_mode_reg fields
	localparam int          OSC_STOP_BIT  = 1;
	localparam int          SLOW_SEL_BIT  = 2;
	localparam int          MODE_LSB      = 3;
	localparam int          MODE_MSB      = 4;
	localparam logic [1:0]  MODE_NORMAL   = 2'h0;
	localparam logic [1:0]  MODE_PD       = 2'h1;
	localparam logic [1:0]  MODE_GREEN    = 2'h2;

	// flag and enable positions
	localparam int          WAKE_IRQ_BIT  = 0;
	localparam int          WAKE_IEN_BIT  = 0;
	localparam int          STAT_WAKE_BIT = 0;
	localparam int          STAT_EXT_LSB  = 1;

	// reset values
	localparam logic [1:0]  MODE_RST      = 2'h0;
	localparam logic [3:0]  P1_WAKE_RST   = 4'h0;
	localparam logic [1:0]  EXT_EN_RST    = 2'h0;

	// pins
	localparam int          FIRST_PORT_W  = 8;
	localparam int          SECOND_PORT_W = 4;
	localparam int          EXT_INT_W     = 2;

	// warm-up, in high-speed oscillator clocks
	localparam int          WARM_CNT_W    = 12;
	localparam logic [11:0] WARM_XTAL_CLKS = 12'h800;
	localparam logic [11:0] WARM_RC_CLKS   = 12'h020;

	// wake interrupt vector
	localparam logic [7:0]  WAKE_VECTOR   = 8'h08;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_SLEEP = 2'b01,
		ST_WARM  = 2'b11,
		ST_GREEN = 2'b10
	} lpm_state_t;

endpackage

// ### hdl/wake_pin_if.sv
// pin wake-up detector to controller connection
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface wake_pin_if;
	logic                                 arm;
	logic [lpm_pkg::FIRST_PORT_W-1:0]     p0_change;
	logic [lpm_pkg::SECOND_PORT_W-1:0]    p1_change;

	modport ctl (output arm, input p0_change, input p1_change);
	modport det (input arm, output p0_change, output p1_change);
endinterface

// ### hdl/wake_pin_detect.sv
// synchronises the wake ports and flags level changes against a reference
// assumes arm is high while running; the reference freezes when it drops
`timescale 1ns/1ps
module wake_pin_detect (
	// clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	// port pins
	input  wire logic [lpm_pkg::FIRST_PORT_W-1:0]  first_port_i,
	input  wire logic [lpm_pkg::SECOND_PORT_W-1:0] second_port_i,
	// controller side
	wake_pin_if.det                                wk
);

	localparam int PW = lpm_pkg::FIRST_PORT_W + lpm_pkg::SECOND_PORT_W;

	typedef struct packed {
		logic [PW-1:0] s1;
		logic [PW-1:0] s2;
		logic [PW-1:0] s3;
		logic [PW-1:0] ref_lvl;
	} det_state_t;

	det_state_t q;
	det_state_t d;
	logic [PW-1:0] chg;

	// a pin counts as changed only once stages two and three agree
	always_comb begin
		d    = q;
		d.s1 = {second_port_i, first_port_i};
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (wk.arm) begin
			d.ref_lvl = q.s3;
		end
	end

	// either edge counts; the clock keeps running in this model, an
	// analogue latch would be needed where the clock truly stops
	assign chg = ~(q.s2 ^ q.s3) & (q.s3 ^ q.ref_lvl);
	assign wk.p0_change = chg[lpm_pkg::FIRST_PORT_W-1:0];
	assign wk.p1_change = chg[PW-1:lpm_pkg::FIRST_PORT_W];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// ### hdl/low_power_mode_wakeup_ctrl.sv
// low-power mode controller: power-down and green entry, pin and timer
// wake-up, oscillator warm-up and wake flags, behind a wishbone slave
// assumes one clock that keeps running; oscillator enables go to the
// clock generator, hosc_tick_i is one pulse per high-speed oscillator clock
`timescale 1ns/1ps
module low_power_mode_wakeup_ctrl (
	// clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	// wishbone slave
	input  wire logic                              wb_cyc_i,
	input  wire logic                              wb_stb_i,
	input  wire logic                              wb_we_i,
	input  wire logic [lpm_pkg::ADR_W-1:0]         wb_adr_i,
	input  wire logic [3:0]                        wb_sel_i,
	input  wire logic [lpm_pkg::DATA_W-1:0]        wb_dat_i,
	output logic      [lpm_pkg::DATA_W-1:0]        wb_dat_o,
	output logic                                   wb_ack_o,
	// wake pins
	input  wire logic [lpm_pkg::FIRST_PORT_W-1:0]  first_port_i,
	input  wire logic [lpm_pkg::SECOND_PORT_W-1:0] second_port_i,
	// timer and oscillator status
	input  wire logic                              basic_timer_ovf_i,
	input  wire logic                              hosc_tick_i,
	input  wire logic                              high_osc_is_rc_i,
	// cpu and clock control
	output logic                                   cpu_halt_o,
	output logic                                   high_osc_en_o,
	output logic                                   fast_rc_en_o,
	output logic                                   slow_rc_en_o,
	output logic                                   sys_clk_slow_o,
	output logic                                   periph_clk_en_o,
	// interrupt requests
	output logic                                   wake_irq_req_o,
	output logic [7:0]                             irq_vector_o,
	output logic [lpm_pkg::EXT_INT_W-1:0]          ext_irq_flag_o
);

	typedef struct packed {
		lpm_pkg::lpm_state_t                  state;
		logic [1:0]                           cpu_mode_field;
		logic                                 slow_clock_select;
		logic                                 high_osc_stop;
		logic                                 wakeup_irq_flag;
		logic                                 wakeup_irq_enable;
		logic                                 wake_flag;
		logic [lpm_pkg::EXT_INT_W-1:0]        ext_flag;
		logic [lpm_pkg::EXT_INT_W-1:0]        ext_en;
		logic [lpm_pkg::SECOND_PORT_W-1:0]    second_port_wake_enable;
		logic [lpm_pkg::WARM_CNT_W-1:0]       warm_cnt;
		logic                                 ack;
		logic [lpm_pkg::DATA_W-1:0]           dat;
		logic                                 halt;
		logic                                 hi_osc_en;
		logic                                 fast_rc_en;
		logic                                 slow_rc_en;
		logic                                 clk_slow;
		logic                                 periph_en;
		logic                                 wake_req;
		logic [7:0]                           vector;
	} ctrl_state_t;

	ctrl_state_t q;
	ctrl_state_t d;

	wake_pin_if wk ();

	wake_pin_detect u_detect (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.first_port_i  (first_port_i),
		.second_port_i (second_port_i),
		.wk            (wk)
	);

	// reference levels track the pins only while instructions run
	assign wk.arm = (q.state == lpm_pkg::ST_RUN);

	logic                               access;
	logic [lpm_pkg::IDX_W-1:0]          idx;
	logic                               in_range;
	logic [lpm_pkg::REG_W-1:0]          rd;
	logic [lpm_pkg::REG_W-1:0]          wr;
	logic                               wr_en;
	logic [lpm_pkg::EXT_INT_W-1:0]      ext_hit;
	logic                               port_wake;
	logic                               hi_on;
	logic [lpm_pkg::WARM_CNT_W-1:0]     warm_last;
	logic                               p0_wake;
	logic                               p1_wake;
	logic                               ext_only;
	logic                               enter_pd;
	logic                               enter_green;
	logic                               no_sys_clk;
	logic                               green_wake;
	logic                               warm_done;
	logic                               slow_on;
	logic                               per_on;

	assign access   = wb_cyc_i & wb_stb_i & ~q.ack;
	assign idx      = wb_adr_i[lpm_pkg::IDX_LSB +: lpm_pkg::IDX_W];
	assign in_range = (wb_adr_i[lpm_pkg::ADR_W-1:
		lpm_pkg::IDX_LSB+lpm_pkg::IDX_W] == '0) &
		(wb_adr_i[lpm_pkg::IDX_LSB-1:0] == '0);
	assign wr       = wb_dat_i[lpm_pkg::REG_W-1:0];
	assign wr_en    = access & wb_we_i & wb_sel_i[0] & in_range;

	// pins 0 and 1 of the first port double as external interrupts
	assign ext_hit   = wk.p0_change[lpm_pkg::EXT_INT_W-1:0] & q.ext_en;
	assign ext_only  = |ext_hit;
	// the first port has no enable; each second port pin has its own
	assign p0_wake   = |wk.p0_change;
	assign p1_wake   = |(wk.p1_change & q.second_port_wake_enable);
	assign port_wake = p0_wake | p1_wake;

	// rc high clocks settle much sooner than crystals
	assign warm_last = (high_osc_is_rc_i ? lpm_pkg::WARM_RC_CLKS :
		lpm_pkg::WARM_XTAL_CLKS) - 12'h001;

	// the reserved mode code 11 decodes as neither and is handled as normal mode
	assign enter_pd    = (q.cpu_mode_field == lpm_pkg::MODE_PD);
	assign enter_green = (q.cpu_mode_field == lpm_pkg::MODE_GREEN);
	// the high clock stopped while the slow clock is not selected leaves nothing to run on
	assign no_sys_clk  = ~q.slow_clock_select & q.high_osc_stop;
	// overflow only matters in green; sleep has no running timer
	assign green_wake  = port_wake | basic_timer_ovf_i;
	// ticks stop with the oscillator, so warm-up cannot end early
	assign warm_done   = hosc_tick_i & (q.warm_cnt == warm_last);

	// read mux; unmapped or misaligned addresses read as zero
	always_comb begin
		rd = '0;
		if (in_range) begin
			unique case (idx)
				lpm_pkg::IDX_OSC_MODE: begin
					rd[lpm_pkg::MODE_MSB:lpm_pkg::MODE_LSB] =
						q.cpu_mode_field;
					rd[lpm_pkg::SLOW_SEL_BIT] = q.slow_clock_select;
					rd[lpm_pkg::OSC_STOP_BIT] = q.high_osc_stop;
				end
				lpm_pkg::IDX_IRQ_REQ: begin
					rd[lpm_pkg::WAKE_IRQ_BIT] = q.wakeup_irq_flag;
				end
				lpm_pkg::IDX_IRQ_EN: begin
					rd[lpm_pkg::WAKE_IEN_BIT] = q.wakeup_irq_enable;
				end
				lpm_pkg::IDX_P1_WAKE: begin
					rd[lpm_pkg::SECOND_PORT_W-1:0] =
						q.second_port_wake_enable;
				end
				lpm_pkg::IDX_WAKE_STAT: begin
					rd[lpm_pkg::STAT_WAKE_BIT] = q.wake_flag;
					rd[lpm_pkg::STAT_EXT_LSB +: lpm_pkg::EXT_INT_W] =
						q.ext_flag;
				end
				lpm_pkg::IDX_EXT_EN: begin
					rd[lpm_pkg::EXT_INT_W-1:0] = q.ext_en;
				end
				default: begin
					rd = '0;
				end
			endcase
		end
	end

	always_comb begin
		d     = q;
		d.ack = access;
		if (access) begin
			d.dat = {{(lpm_pkg::DATA_W-lpm_pkg::REG_W){1'b0}}, rd};
		end

		// software writes first, so hardware events below win
		if (wr_en) begin
			unique case (idx)
				lpm_pkg::IDX_OSC_MODE: begin
					d.cpu_mode_field =
						wr[lpm_pkg::MODE_MSB:lpm_pkg::MODE_LSB];
					d.slow_clock_select = wr[lpm_pkg::SLOW_SEL_BIT];
					d.high_osc_stop = wr[lpm_pkg::OSC_STOP_BIT];
				end
				lpm_pkg::IDX_IRQ_REQ: begin
					d.wakeup_irq_flag = wr[lpm_pkg::WAKE_IRQ_BIT];
				end
				lpm_pkg::IDX_IRQ_EN: begin
					d.wakeup_irq_enable = wr[lpm_pkg::WAKE_IEN_BIT];
				end
				lpm_pkg::IDX_P1_WAKE: begin
					d.second_port_wake_enable =
						wr[lpm_pkg::SECOND_PORT_W-1:0];
				end
				lpm_pkg::IDX_WAKE_STAT: begin
					d.wake_flag = wr[lpm_pkg::STAT_WAKE_BIT];
					d.ext_flag =
						wr[lpm_pkg::STAT_EXT_LSB +: lpm_pkg::EXT_INT_W];
				end
				lpm_pkg::IDX_EXT_EN: begin
					d.ext_en = wr[lpm_pkg::EXT_INT_W-1:0];
				end
				default: begin
					d.ext_en = d.ext_en;
				end
			endcase
		end

		// halted states change only the fields named below; all other
		// registers hold their contents across the low-power period
		unique case (q.state)
			lpm_pkg::ST_RUN: begin
				if (enter_pd) begin
					d.state = lpm_pkg::ST_SLEEP;
				end else if (no_sys_clk) begin
					// no system clock left in normal mode
					d.state = lpm_pkg::ST_SLEEP;
				end else if (enter_green) begin
					d.state = lpm_pkg::ST_GREEN;
				end
			end
			lpm_pkg::ST_SLEEP: begin
				// timer overflow is not looked at here
				if (port_wake) begin
					d.state = lpm_pkg::ST_WARM;
					d.warm_cnt = '0;
					d.cpu_mode_field = lpm_pkg::MODE_NORMAL;
					d.slow_clock_select = 1'b0;
					// the stop bit clears so the high clock restarts
					d.high_osc_stop = 1'b0;
					if (ext_only) begin
						d.ext_flag = q.ext_flag | ext_hit;
					end else begin
						d.wake_flag = 1'b1;
						d.wakeup_irq_flag = 1'b1;
					end
				end
			end
			lpm_pkg::ST_WARM: begin
				if (warm_done) begin
					d.state = lpm_pkg::ST_RUN;
					d.warm_cnt = '0;
				end else if (hosc_tick_i) begin
					d.warm_cnt = q.warm_cnt + 12'h001;
				end
			end
			lpm_pkg::ST_GREEN: begin
				// pwm, event counter and other timers have no path here
				if (green_wake) begin
					d.state = lpm_pkg::ST_RUN;
					d.cpu_mode_field = lpm_pkg::MODE_NORMAL;
					if (~basic_timer_ovf_i & ext_only) begin
						d.ext_flag = q.ext_flag | ext_hit;
					end else begin
						d.wake_flag = 1'b1;
						d.wakeup_irq_flag = 1'b1;
					end
				end
			end
		endcase

		// registered outputs follow the next state
		hi_on   = 1'b0;
		slow_on = 1'b0;
		per_on  = 1'b0;
		unique case (d.state)
			lpm_pkg::ST_RUN: begin
				hi_on   = ~d.high_osc_stop;
				slow_on = 1'b1;
				per_on  = 1'b1;
			end
			lpm_pkg::ST_SLEEP: begin
				hi_on = 1'b0;
			end
			lpm_pkg::ST_WARM: begin
				// slow rc and peripherals wait for the high clock
				hi_on = 1'b1;
			end
			lpm_pkg::ST_GREEN: begin
				hi_on   = ~d.high_osc_stop;
				slow_on = 1'b1;
				per_on  = 1'b1;
			end
		endcase
		d.halt       = (d.state != lpm_pkg::ST_RUN);
		d.hi_osc_en  = hi_on & ~high_osc_is_rc_i;
		d.fast_rc_en = hi_on & high_osc_is_rc_i;
		d.slow_rc_en = slow_on;
		d.clk_slow   = d.slow_clock_select;
		d.periph_en  = per_on;
		// the flag is what software sees; the request also needs enable
		d.wake_req   = d.wakeup_irq_flag & d.wakeup_irq_enable;
		d.vector     = d.wake_req ? lpm_pkg::WAKE_VECTOR : 8'h00;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// normal mode out of reset: high clock and slow rc running
			q <= '0;
			q.state <= lpm_pkg::ST_RUN;
			q.cpu_mode_field <= lpm_pkg::MODE_RST;
			q.second_port_wake_enable <= lpm_pkg::P1_WAKE_RST;
			q.ext_en <= lpm_pkg::EXT_EN_RST;
			q.hi_osc_en <= 1'b1;
			q.slow_rc_en <= 1'b1;
			q.periph_en <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o        = q.dat;
	assign wb_ack_o        = q.ack;
	assign cpu_halt_o      = q.halt;
	assign high_osc_en_o   = q.hi_osc_en;
	assign fast_rc_en_o    = q.fast_rc_en;
	assign slow_rc_en_o    = q.slow_rc_en;
	assign sys_clk_slow_o  = q.clk_slow;
	assign periph_clk_en_o = q.periph_en;
	assign wake_irq_req_o  = q.wake_req;
	assign irq_vector_o    = q.vector;
	assign ext_irq_flag_o  = q.ext_flag;

endmodule

// ### testbench/low_power_mode_wakeup_ctrl_asserts.sv
// port checker for the low-power mode controller
// assumes one clock, bound onto the top module
`timescale 1ns/1ps
module low_power_mode_wakeup_ctrl_asserts (
	// clock, reset and bus
	input wire logic                        clk_i,
	input wire logic                        rst_i,
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [lpm_pkg::ADR_W-1:0]   wb_adr_i,
	input wire logic [3:0]                  wb_sel_i,
	input wire logic [lpm_pkg::DATA_W-1:0]  wb_dat_i,
	input wire logic                        wb_ack_o,
	// timer, oscillator and mode
	input wire logic                        basic_timer_ovf_i,
	input wire logic                        hosc_tick_i,
	input wire logic                        high_osc_is_rc_i,
	input wire logic                        cpu_halt_o,
	input wire logic                        high_osc_en_o,
	input wire logic                        fast_rc_en_o,
	input wire logic                        slow_rc_en_o,
	input wire logic                        sys_clk_slow_o,
	input wire logic                        periph_clk_en_o,
	input wire logic                        wake_irq_req_o,
	input wire logic [7:0]                  irq_vector_o,
	input wire logic [lpm_pkg::EXT_INT_W-1:0] ext_irq_flag_o
);
	logic [11:0] tick_cnt_q;
	logic [11:0] tick_cnt_d;
	// warm-up ticks, counted only while halted with peripherals off
	always_comb begin
		tick_cnt_d = tick_cnt_q;
		if (!cpu_halt_o)
			tick_cnt_d = 12'h000;
		else if (hosc_tick_i && !periph_clk_en_o)
			tick_cnt_d = tick_cnt_q + 12'h001;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			tick_cnt_q <= 12'h000;
		else
			tick_cnt_q <= tick_cnt_d;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_mode_wr;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
		wb_adr_i == {2'b00, lpm_pkg::IDX_OSC_MODE, 2'b00} && !cpu_halt_o;
	endsequence
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
	property p_pd_entry;
		s_mode_wr ##0 (wb_dat_i[4:3] == lpm_pkg::MODE_PD)
			|-> ##[2:3] (cpu_halt_o && !periph_clk_en_o);
	endproperty
	a_pd_entry: assert property (p_pd_entry)
		else $error("no power-down");
	property p_green_entry;
		s_mode_wr ##0 (wb_dat_i[4:3] == lpm_pkg::MODE_GREEN)
			|-> ##[2:3] (cpu_halt_o && periph_clk_en_o);
	endproperty
	a_green_entry: assert property (p_green_entry)
		else $error("no green");
	property p_pd_osc;
		$rose(cpu_halt_o) && !periph_clk_en_o
			|-> !high_osc_en_o && !fast_rc_en_o && !slow_rc_en_o;
	endproperty
	a_pd_osc: assert property (p_pd_osc)
		else $error("osc left on");
	property p_green_ovf;
		cpu_halt_o && periph_clk_en_o && basic_timer_ovf_i |=> !cpu_halt_o;
	endproperty
	a_green_ovf: assert property (p_green_ovf)
		else $error("slow wake");
	property p_vec;
		irq_vector_o == (wake_irq_req_o ? lpm_pkg::WAKE_VECTOR : 8'h00);
	endproperty
	a_vec: assert property (p_vec)
		else $error("bad vector");
	property p_flag_hold;
		wake_irq_req_o && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> wake_irq_req_o;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag lost");
	property p_warm;
		$fell(cpu_halt_o) && !$past(periph_clk_en_o) |-> (high_osc_is_rc_i ?
			tick_cnt_q inside {[31:33]} : tick_cnt_q inside {[2047:2049]});
	endproperty
	a_warm: assert property (p_warm)
		else $error("bad warm-up");
	property p_pd_normal;
		$fell(cpu_halt_o) && !$past(periph_clk_en_o) |-> !sys_clk_slow_o;
	endproperty
	a_pd_normal: assert property (p_pd_normal)
		else $error("not normal");
	c_pd_wake: cover property ($fell(cpu_halt_o) && !$past(periph_clk_en_o));
	c_green_wake: cover property (cpu_halt_o && periph_clk_en_o ##1 !cpu_halt_o);
	c_ext: cover property ($rose(ext_irq_flag_o[0]));
endmodule
bind low_power_mode_wakeup_ctrl low_power_mode_wakeup_ctrl_asserts u_asserts (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_ack_o, .basic_timer_ovf_i, .hosc_tick_i, .high_osc_is_rc_i,
	.cpu_halt_o, .high_osc_en_o, .fast_rc_en_o, .slow_rc_en_o, .sys_clk_slow_o,
	.periph_clk_en_o, .wake_irq_req_o, .irq_vector_o, .ext_irq_flag_o);

// ### testbench/pin_timer_model.sv
// far side model: high oscillator ticks and basic timer overflow
// assumes ticks only while an oscillator enable is high
`timescale 1ns/1ps
module pin_timer_model #(
	parameter int PERIOD = 20
) (
	// clock and controls
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic osc_on_i,
	input  wire logic sys_clk_on_i,
	input  wire logic run_i,
	input  wire logic stray_i,
	// outputs
	output logic      hosc_tick_o,
	output logic      ovf_o
);
	int cnt;
	// a stopped oscillator gives no ticks, so warm-up cannot end early
	always_ff @(posedge clk_i) begin
		if (rst_i || !osc_on_i)
			hosc_tick_o <= 1'b0;
		else
			hosc_tick_o <= !hosc_tick_o;
	end
	// stray_i fakes an overflow with the system clock stopped
	always_ff @(posedge clk_i) begin
		ovf_o <= 1'b0;
		if (rst_i || !run_i) begin
			cnt <= 0;
		end else if (sys_clk_on_i || stray_i) begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			ovf_o <= (cnt == PERIOD - 1);
		end
	end
endmodule

// ### testbench/low_power_mode_wakeup_ctrl_tb.sv
// bench: register access, power-down and green entry and wake-up
// assumes the one-cycle bus answer of the controller
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
	n_fail++; $display("wrong value at %0t: got %h expected %h", \
	$time, got, exp); end end
module low_power_mode_wakeup_ctrl_tb;
	logic clk_i, rst_i, cyc, stb, we, is_rc, run, stray;
	logic [11:0] adr;
	logic [31:0] wdat, rdat;
	logic [7:0] rdv, fp;
	logic [3:0] sp;
	logic ack, halt, hosc_en, fast_en, slow_en, slow_sel, periph, wirq;
	logic tick, ovf;
	logic [7:0] vec;
	logic [1:0] ext;
	int n_fail = 0;
	int n_tests = 0;
	int n;
	low_power_mode_wakeup_ctrl u_low_power_mode_wakeup_ctrl (
		.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .first_port_i(fp), .second_port_i(sp),
		.basic_timer_ovf_i(ovf), .hosc_tick_i(tick), .high_osc_is_rc_i(is_rc),
		.cpu_halt_o(halt), .high_osc_en_o(hosc_en), .fast_rc_en_o(fast_en),
		.slow_rc_en_o(slow_en), .sys_clk_slow_o(slow_sel),
		.periph_clk_en_o(periph), .wake_irq_req_o(wirq), .irq_vector_o(vec),
		.ext_irq_flag_o(ext));
	pin_timer_model u_pin_timer_model (
		.clk_i, .rst_i, .osc_on_i(hosc_en | fast_en), .sys_clk_on_i(periph),
		.run_i(run), .stray_i(stray), .hosc_tick_o(tick), .ovf_o(ovf));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = !clk_i;
	end
	task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {2'b00, idx, 2'b00};
		wdat <= {24'h0000_00, d};
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		rdv = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (t >= 50) n_fail++;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
		bus(idx, 1'b0, 8'h00);
		`CHK(rdv, e)
	endtask
	// bounded wait for the halt level, returns cycles spent
	task automatic wait_halt(input logic v, output int c);
		c = 0;
		while (halt !== v && c < 6000) begin
			@(posedge clk_i);
			c++;
		end
		if (c >= 6000) n_fail++;
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		end_of_test();
	end
	initial begin
		{cyc, stb, we, run, stray} = 5'h00;
		{rst_i, is_rc} = 2'b11;
		adr = 12'h000;
		wdat = 32'h0000_0000;
		fp = 8'h00;
		sp = 4'hF;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(lpm_pkg::IDX_OSC_MODE, 8'h00);
		rd_chk(lpm_pkg::IDX_P1_WAKE, 8'h00);
		rd_chk(8'h10, 8'h00);
		wr(lpm_pkg::IDX_IRQ_EN, 8'h01);
		for (int k = 1; k >= 0; k--) begin
			is_rc <= k[0];
			wr(lpm_pkg::IDX_OSC_MODE, k ? 8'h08 : 8'h0C);
			wait_halt(1'b1, n);
			@(posedge clk_i);
			`CHK({hosc_en, fast_en, slow_en, periph}, 4'h0)
			run <= 1'b1;
			stray <= 1'b1;
			sp <= sp ^ 4'h1;
			repeat (60) @(posedge clk_i);
			`CHK(halt, 1'b1)
			{run, stray} <= 2'b00;
			fp <= fp ^ 8'h80;
			wait_halt(1'b0, n);
			`CHK(n inside {[(k ? 64 : 4096):(k ? 76 : 4108)]}, 1'b1)
			`CHK({slow_sel, vec}, {1'b0, lpm_pkg::WAKE_VECTOR})
			rd_chk(lpm_pkg::IDX_OSC_MODE, 8'h00);
			rd_chk(lpm_pkg::IDX_WAKE_STAT, 8'h01);
			wr(lpm_pkg::IDX_IRQ_REQ, 8'h00);
			wr(lpm_pkg::IDX_WAKE_STAT, 8'h00);
			`CHK(wirq, 1'b0)
		end
		wr(lpm_pkg::IDX_P1_WAKE, 8'hFF);
		rd_chk(lpm_pkg::IDX_P1_WAKE, 8'h0F);
		wr(lpm_pkg::IDX_OSC_MODE, 8'h14);
		wait_halt(1'b1, n);
		`CHK(periph, 1'b1)
		run <= 1'b1;
		wait_halt(1'b0, n);
		`CHK(n <= 24, 1'b1)
		run <= 1'b0;
		rd_chk(lpm_pkg::IDX_OSC_MODE, 8'h04);
		`CHK({slow_sel, wirq}, 2'b11)
		wr(lpm_pkg::IDX_OSC_MODE, 8'h10);
		wait_halt(1'b1, n);
		sp <= sp & 4'h7;
		wait_halt(1'b0, n);
		`CHK(n <= 8, 1'b1)
		rd_chk(lpm_pkg::IDX_OSC_MODE, 8'h00);
		{is_rc, fp} <= {1'b1, 8'h00};
		wr(lpm_pkg::IDX_IRQ_REQ, 8'h00);
		wr(lpm_pkg::IDX_WAKE_STAT, 8'h00);
		wr(lpm_pkg::IDX_EXT_EN, 8'h01);
		wr(lpm_pkg::IDX_OSC_MODE, 8'h02);
		wait_halt(1'b1, n);
		fp <= 8'h01;
		wait_halt(1'b0, n);
		`CHK({ext, wirq}, 3'b010)
		rd_chk(lpm_pkg::IDX_WAKE_STAT, 8'h02);
		end_of_test();
	end
endmodule
